/* include/arm_consts.svh */
// Purpose: offsets, reset values, unlock key, device address, CRC polynomial and mode code of the upper register map
// Assumes: included by bare name wherever needed
// Notes:   definitions only
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH
`define ARM_ADDR_INTERVAL   4'h8
`define ARM_ADDR_OFFSET     4'h9
`define ARM_ADDR_GAIN       4'ha
`define ARM_ADDR_RSV_B      4'hb
`define ARM_ADDR_RSV_C      4'hc
`define ARM_ADDR_PASSWORD   4'hd
`define ARM_ADDR_RSV_E      4'he
`define ARM_ADDR_CHECKSUM   4'hf
`define ARM_RST_INTERVAL    24'h000000
`define ARM_RST_OFFSET      24'h000000
`define ARM_RST_GAIN        24'h800000
`define ARM_RST_RSV_B       24'h900000
`define ARM_RST_RSV_C       8'h30
`define ARM_RST_PASSWORD    8'ha5
`define ARM_RST_RSV_E       16'h0000
`define ARM_RST_CHECKSUM    16'h0000
`define ARM_UNLOCK_KEY      8'ha5
`define ARM_DEV_ADDR        2'b01
`define ARM_CRC_POLY        16'h8005
`define ARM_MODE_CONT       2'b11
`endif

/* include/arm_pkg.sv */
// Purpose: types of the upper register map block
// Assumes: nothing
// Notes:   constants live in arm_consts.svh
package arm_pkg;
    // scan sequencer states
    typedef enum logic [1:0] {
        ARM_IDLE = 2'b00,
        ARM_SCAN = 2'b01,
        ARM_WAIT = 2'b10
    } arm_seq_e;
    // register write request from the serial front end
    typedef struct packed {
        logic        valid;
        logic [7:0]  cmd;
        logic [23:0] data;
    } arm_wreq_s;
    // all state of the block except the read acknowledge and CRC reference registers
    typedef struct packed {
        logic [23:0] interval;
        logic [23:0] offset;
        logic [23:0] gain;
        logic [23:0] rsv_b;
        logic [7:0]  rsv_c;
        logic [7:0]  password;
        logic [15:0] rsv_e;
        logic [15:0] checksum;
        logic [3:0]  crc_idx;
        logic [15:0] crc_acc;
        logic        crc_ok;
        arm_seq_e    seq;
        logic [23:0] wait_cnt;
        logic        go_standby;
        logic        go_shutdown;
        logic        next_cycle;
        logic [23:0] rdata;
    } arm_state_s;
endpackage

/* sim/arm_host_model.sv */
// Purpose: host controller model issuing addressed register commands to the upper map
// Assumes: requests launched 1 ns after a rising edge and held for one full cycle
// Notes:   released command and data lines show scrambled values, never the last ones
`timescale 1ns/1ps
module arm_host_model (
    input  wire logic               clock_in,     // system clock
    output arm_pkg::arm_wreq_s      wr_out,       // write request towards the map
    output logic                    rd_valid_out, // read strobe
    output logic [7:0]              rd_cmd_out    // read command byte
);
    // idle lines at time zero
    initial begin
        wr_out = '0;
        rd_valid_out = 1'b0;
        rd_cmd_out = 8'h00;
    end
    // one write: device address on top bits, register address below, data whole
    task automatic write(input logic [1:0] dev, input logic [3:0] addr, input logic [23:0] data);
        @(posedge clock_in);
        #1;
        wr_out = '{1'b1, {dev, addr, 2'b00}, data};
        @(posedge clock_in);
        #1;
        // released: inverse of the last value so nothing stale looks valid
        wr_out = '{1'b0, ~wr_out.cmd, ~wr_out.data};
    endtask
    // one read strobe, answer is watched by the bench
    task automatic read(input logic [1:0] dev, input logic [3:0] addr);
        @(posedge clock_in);
        #1;
        rd_valid_out = 1'b1;
        rd_cmd_out = {dev, addr, 2'b00};
        @(posedge clock_in);
        #1;
        rd_valid_out = 1'b0;
        rd_cmd_out = ~rd_cmd_out;
    endtask
endmodule

/* sim/tb_arm_regmap.sv */
// Purpose: self-checking bench of the upper register map
// Assumes: reads answered one cycle after the strobe; pulses last one cycle
// Notes:   expected read data queued by the driver, popped by the read monitor
`timescale 1ns/1ps
`include "arm_consts.svh"
module tb_arm_regmap;
    logic               clock_in;    // 50 MHz clock
    logic               rst_n_in;    // synchronous reset, active low
    arm_pkg::arm_wreq_s wr_w;        // write request from host model
    logic               rd_valid_w;  // read strobe from host model
    logic [7:0]         rd_cmd_w;    // read command from host model
    logic               master_run;  // master clock running
    logic [1:0]         cnv_sel;     // conversion mode
    logic               scan_done;   // scan cycle finished
    logic [23:0]        rd_data;     // read data
    logic               rd_ack;      // read answered
    logic [23:0]        offset_code; // offset code out
    logic [23:0]        gain_code;   // gain code out
    logic               locked;      // map locked
    logic               crc_flag;    // 1 = no crc error
    logic [2:0]         pulses;      // start, standby, shutdown
    int                 n_mismatch;  // mismatches seen
    int                 tests_run;   // comparisons made
    int                 seed;        // random seed
    int                 n;           // random interval
    logic [23:0]        expq [$];    // expected read data
    logic [23:0]        iv, of, gn;  // shadow of timer, offset, gain
    logic [15:0]        crc;         // expected checksum
    logic [23:0]        rv [8] = '{24'h0, 24'h0, 24'h800000, 24'h900000, 24'h30, 24'ha5, 24'h0, 24'h0};

    arm_host_model host (.clock_in(clock_in), .wr_out(wr_w), .rd_valid_out(rd_valid_w), .rd_cmd_out(rd_cmd_w));
    arm_regmap dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .wr_in(wr_w), .rd_valid_in(rd_valid_w), .rd_cmd_in(rd_cmd_w),
        .master_clock_run_in(master_run), .conversion_mode_field_in(cnv_sel), .scan_done_in(scan_done),
        .rd_data_out(rd_data),
        .rd_ack_out(rd_ack), .offset_code_out(offset_code), .gain_code_out(gain_code), .locked_out(locked),
        .config_crc_error_flag_out(crc_flag), .scan_start_out(pulses[2]), .go_standby_out(pulses[1]),
        .go_shutdown_out(pulses[0]));

    // clock generator
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // compare and count
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // write with the correct device address
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        host.write(`ARM_DEV_ADDR, a, d);
    endtask
    // read with the correct device address, expectation queued first
    task automatic rd(input logic [3:0] a, input logic [23:0] exp);
        expq.push_back(exp);
        host.read(`ARM_DEV_ADDR, a);
    endtask
    // one scan end, count cycles until a pulse shows, check which one
    task automatic scan_chk(input logic [1:0] mode, input int wait_n, input logic [2:0] exp);
        int cnt;
        cnt = 0;
        @(posedge clock_in);
        #1;
        cnv_sel = mode;
        scan_done = 1'b1;
        do begin
            @(posedge clock_in);
            #1;
            scan_done = 1'b0;
            cnt++;
        end while (pulses === 3'b000 && cnt < 60);
        chk("scan delay", 24'(wait_n + 1), 24'(cnt));
        chk("scan pulse", {21'h0, exp}, {21'h0, pulses});
        repeat (4) @(posedge clock_in);
    endtask
    // read monitor: each answer takes the oldest note
    always @(negedge clock_in) begin
        if (rd_ack === 1'b1) begin
            if (expq.size() == 0) begin
                chk("unexpected read ack", 24'h0, 24'h1);
            end else begin
                chk("read data", expq.pop_front(), rd_data);
            end
        end
    end
    // watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
    // main sequence
    initial begin
        seed = 32'h09fa;
        n_mismatch = 0;
        tests_run = 0;
        rst_n_in = 1'b0;
        master_run = 1'b1;
        cnv_sel = 2'b11;
        scan_done = 1'b0;
        repeat (6) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        for (int i = 0; i < 8; i++) rd(4'(8 + i), rv[i]);
        of = 24'($random(seed));
        gn = 24'($random(seed));
        wr(`ARM_ADDR_OFFSET, of);
        wr(`ARM_ADDR_GAIN, gn);
        host.write(2'b10, `ARM_ADDR_GAIN, ~gn);
        rd(`ARM_ADDR_OFFSET, of);
        rd(`ARM_ADDR_GAIN, gn);
        rd(4'h3, 24'h0);
        host.read(2'b00, `ARM_ADDR_GAIN);
        repeat (3) @(posedge clock_in);
        chk("offset code", of, offset_code);
        chk("gain code", gn, gain_code);
        // continuous with zero, then random wait; one-shot modes
        iv = 24'h0;
        scan_chk(2'b11, 0, 3'b100);
        n = {$random(seed)} % 8;
        iv = 24'(n);
        wr(`ARM_ADDR_INTERVAL, iv);
        scan_chk(2'b11, n, 3'b100);
        scan_chk(2'b10, 0, 3'b010);
        scan_chk(2'b00, 0, 3'b001);
        scan_chk(2'b01, 0, 3'b001);
        wr(`ARM_ADDR_RSV_B, 24'h900000);
        wr(`ARM_ADDR_RSV_C, 24'h30);
        wr(`ARM_ADDR_RSV_E, 24'h00000d);
        // expected checksum over timer, offset, gain, reserved bytes
        crc = 16'hffff;
        for (int i = 0; i < 15; i++) begin
            crc ^= {8'(({iv, of, gn, 24'h900000, 8'h30, 16'h000d} >> (112 - 8 * i))), 8'h00};
            for (int j = 0; j < 8; j++) crc = crc[15] ? ((crc << 1) ^ `ARM_CRC_POLY) : (crc << 1);
        end
        master_run = 1'b0;
        wr(`ARM_ADDR_PASSWORD, 24'h3c);
        wr(`ARM_ADDR_OFFSET, ~of);
        repeat (40) @(posedge clock_in);
        chk("locked", 24'h1, {23'h0, locked});
        rd(`ARM_ADDR_OFFSET, of);
        rd(`ARM_ADDR_CHECKSUM, 24'h0);
        rd(`ARM_ADDR_PASSWORD, 24'h3c);
        #1;
        master_run = 1'b1;
        repeat (40) @(posedge clock_in);
        rd(`ARM_ADDR_CHECKSUM, {8'h0, crc});
        chk("crc flag", 24'h1, {23'h0, crc_flag});
        wr(`ARM_ADDR_PASSWORD, 24'ha5);
        repeat (3) @(posedge clock_in);
        chk("locked", 24'h0, {23'h0, locked});
        rd(`ARM_ADDR_CHECKSUM, 24'h0);
        repeat (4) @(posedge clock_in);
        chk("reads left unanswered", 24'h0, 24'(expq.size()));
        final_report();
    end
endmodule

/* verilog/arm_regmap.sv */
// Purpose: upper register map 0x8..0xf with write lock, config CRC and scan interval timer
// Assumes: write/read commands already decoded by the serial front end; master_clock_run_in marks running master clock
// Notes:   command byte bits 7:6 device address, 5:2 register address
// What this block does
// [RQ1] wait interval-code master clock periods between scans
// [RQ2] offset code is two's complement correction
// [RQ3] gain code unsigned, 800000 hex unity
// [RQ4] host keeps 0xb at 0x900000
// [RQ5] host keeps 0xc at 0x30
// [RQ6] key 0xa5: writes open, checksum zero
// [RQ7] other key: only password register writable
// [RQ8] locked checksum updates only while clock runs
// [RQ9] read-only 16-bit config CRC register
// [RQ10] act only when command address matches
// [RQ11] timer only in continuous mode
// [RQ12] crc flag low means CRC error
// [RQ13] refused write changes nothing else
// [RQ14] host programs 0xe variant value
`timescale 1ns/1ps
`include "arm_consts.svh"
module arm_regmap #(
    parameter logic [1:0] DEV_ADDR = `ARM_DEV_ADDR  // device address of this part
) (
    input  wire logic               clock_in,         // system clock, 50 MHz
    input  wire logic               rst_n_in,         // synchronous reset, active low
    input  wire arm_pkg::arm_wreq_s wr_in,            // write request
    input  wire logic               rd_valid_in,      // read request strobe
    input  wire logic [7:0]         rd_cmd_in,        // read command byte
    input  wire logic               master_clock_run_in,      // master clock running
    input  wire logic [1:0]         conversion_mode_field_in, // conversion_mode_field
    input  wire logic               scan_done_in,     // pulse: scan cycle finished
    output logic [23:0]             rd_data_out,      // read data, one cycle after request
    output logic                    rd_ack_out,       // read answered
    output logic [23:0]             offset_code_out,  // signed offset correction
    output logic [23:0]             gain_code_out,    // unsigned gain correction
    output logic                    locked_out,       // map locked
    output logic                    config_crc_error_flag_out, // 0 = crc error
    output logic                    scan_start_out,   // pulse: start next scan cycle
    output logic                    go_standby_out,   // pulse: one-shot to standby
    output logic                    go_shutdown_out   // pulse: one-shot to shutdown
);
    arm_pkg::arm_state_s st_r;    // registered state
    arm_pkg::arm_state_s st_nxt;  // next state
    logic                rd_ack_r;  // read answered flag
    logic [15:0]         crc_ref_r; // first nonzero checksum after locking, for error compare

    // address match of a command byte
    function automatic logic addr_hit(input logic [7:0] cmd);
        addr_hit = (cmd[7:6] == DEV_ADDR);
    endfunction

    // one CRC-16 step over a byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            if (x[15] ^ d[i]) begin
                x = {x[14:0], 1'b0} ^ `ARM_CRC_POLY;
            end else begin
                x = {x[14:0], 1'b0};
            end
        end
        crc_byte = x;
    endfunction

    // configuration byte stream covered by the checksum
    function automatic logic [7:0] cfg_byte(input arm_pkg::arm_state_s s, input logic [3:0] i);
        case (i)
            4'h0:    cfg_byte = s.interval[23:16];
            4'h1:    cfg_byte = s.interval[15:8];
            4'h2:    cfg_byte = s.interval[7:0];
            4'h3:    cfg_byte = s.offset[23:16];
            4'h4:    cfg_byte = s.offset[15:8];
            4'h5:    cfg_byte = s.offset[7:0];
            4'h6:    cfg_byte = s.gain[23:16];
            4'h7:    cfg_byte = s.gain[15:8];
            4'h8:    cfg_byte = s.gain[7:0];
            4'h9:    cfg_byte = s.rsv_b[23:16];
            4'ha:    cfg_byte = s.rsv_b[15:8];
            4'hb:    cfg_byte = s.rsv_b[7:0];
            4'hc:    cfg_byte = s.rsv_c;
            4'hd:    cfg_byte = s.rsv_e[15:8];
            default: cfg_byte = s.rsv_e[7:0];
        endcase
    endfunction

    logic unlocked;  // password holds the unlock key
    assign unlocked = (st_r.password == `ARM_UNLOCK_KEY);

    // next-state logic
    always_comb begin
        logic        wr_go;
        logic [3:0]  wa;
        st_nxt = st_r;
        wr_go = wr_in.valid && addr_hit(wr_in.cmd);  // RQ10
        wa = wr_in.cmd[5:2];
        st_nxt.go_standby = 1'b0;
        st_nxt.go_shutdown = 1'b0;
        st_nxt.next_cycle = 1'b0;
        // register writes; locked map accepts only password, silently
        if (wr_go) begin
            if (wa == `ARM_ADDR_PASSWORD) begin
                st_nxt.password = wr_in.data[7:0];  // RQ7
            end else if (unlocked) begin  // RQ6 RQ7 RQ13
                case (wa)
                    `ARM_ADDR_INTERVAL: st_nxt.interval = wr_in.data;
                    `ARM_ADDR_OFFSET:   st_nxt.offset = wr_in.data;
                    `ARM_ADDR_GAIN:     st_nxt.gain = wr_in.data;
                    `ARM_ADDR_RSV_B:    st_nxt.rsv_b = wr_in.data;  // RQ4
                    `ARM_ADDR_RSV_C:    st_nxt.rsv_c = wr_in.data[7:0];  // RQ5
                    `ARM_ADDR_RSV_E:    st_nxt.rsv_e = wr_in.data[15:0];  // RQ14
                    default:            st_nxt.rsv_c = st_r.rsv_c;  // lower map or read-only
                endcase
            end
        end
        // checksum engine: a byte per running clock while locked
        if (unlocked) begin
            st_nxt.checksum = `ARM_RST_CHECKSUM;  // RQ6
            st_nxt.crc_idx = 4'h0;
            st_nxt.crc_acc = 16'hffff;
            st_nxt.crc_ok = 1'b1;
        end else if (master_clock_run_in) begin  // RQ8
            st_nxt.crc_acc = crc_byte(st_r.crc_acc, cfg_byte(st_r, st_r.crc_idx));
            if (st_r.crc_idx == 4'he) begin
                st_nxt.checksum = st_nxt.crc_acc;  // RQ9
                st_nxt.crc_idx = 4'h0;
                st_nxt.crc_acc = 16'hffff;
            end else begin
                st_nxt.crc_idx = st_r.crc_idx + 4'h1;
            end
        end
        // error flag: locked map must not change after first checksum
        if (!unlocked && crc_ref_r != 16'h0000 && st_r.checksum != 16'h0000
            && st_r.checksum != crc_ref_r) begin
            st_nxt.crc_ok = 1'b0;  // RQ12
        end
        // scan sequencer
        case (st_r.seq)
            arm_pkg::ARM_IDLE: begin
                st_nxt.seq = arm_pkg::ARM_SCAN;
            end
            arm_pkg::ARM_SCAN: begin
                if (scan_done_in) begin
                    if (conversion_mode_field_in == `ARM_MODE_CONT) begin  // RQ11
                        if (st_r.interval == 24'h000000) begin  // RQ1
                            st_nxt.next_cycle = 1'b1;
                        end else begin
                            st_nxt.seq = arm_pkg::ARM_WAIT;
                            st_nxt.wait_cnt = st_r.interval;
                        end
                    end else begin
                        st_nxt.go_standby = conversion_mode_field_in[1];  // RQ11
                        st_nxt.go_shutdown = !conversion_mode_field_in[1];
                        st_nxt.seq = arm_pkg::ARM_IDLE;
                    end
                end
            end
            arm_pkg::ARM_WAIT: begin
                if (master_clock_run_in) begin
                    if (st_r.wait_cnt == 24'h000001) begin  // RQ1
                        st_nxt.next_cycle = 1'b1;
                        st_nxt.seq = arm_pkg::ARM_SCAN;
                    end
                    st_nxt.wait_cnt = st_r.wait_cnt - 24'h000001;
                end
            end
            default: st_nxt.seq = arm_pkg::ARM_IDLE;
        endcase
        // read mux
        st_nxt.rdata = 24'h000000;
        if (rd_valid_in && addr_hit(rd_cmd_in)) begin  // RQ10
            case (rd_cmd_in[5:2])
                `ARM_ADDR_INTERVAL: st_nxt.rdata = st_r.interval;
                `ARM_ADDR_OFFSET:   st_nxt.rdata = st_r.offset;
                `ARM_ADDR_GAIN:     st_nxt.rdata = st_r.gain;
                `ARM_ADDR_RSV_B:    st_nxt.rdata = st_r.rsv_b;
                `ARM_ADDR_RSV_C:    st_nxt.rdata = {16'h0000, st_r.rsv_c};
                `ARM_ADDR_PASSWORD: st_nxt.rdata = {16'h0000, st_r.password};
                `ARM_ADDR_RSV_E:    st_nxt.rdata = {8'h00, st_r.rsv_e};
                `ARM_ADDR_CHECKSUM: st_nxt.rdata = {8'h00, st_r.checksum};  // RQ9
                default:            st_nxt.rdata = 24'h000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_r.interval    <= `ARM_RST_INTERVAL;
            st_r.offset      <= `ARM_RST_OFFSET;
            st_r.gain        <= `ARM_RST_GAIN;  // RQ3
            st_r.rsv_b       <= `ARM_RST_RSV_B;
            st_r.rsv_c       <= `ARM_RST_RSV_C;
            st_r.password    <= `ARM_RST_PASSWORD;
            st_r.rsv_e       <= `ARM_RST_RSV_E;
            st_r.checksum    <= `ARM_RST_CHECKSUM;
            st_r.crc_idx     <= 4'h0;
            st_r.crc_acc     <= 16'hffff;
            st_r.crc_ok      <= 1'b1;
            st_r.seq         <= arm_pkg::ARM_IDLE;
            st_r.wait_cnt    <= 24'h000000;
            st_r.go_standby  <= 1'b0;
            st_r.go_shutdown <= 1'b0;
            st_r.next_cycle  <= 1'b0;
            st_r.rdata       <= 24'h000000;
            rd_ack_r         <= 1'b0;
            crc_ref_r        <= 16'h0000;
        end else begin
            st_r     <= st_nxt;
            rd_ack_r <= rd_valid_in && addr_hit(rd_cmd_in);
            // reference checksum: first one after locking
            if (unlocked) begin
                crc_ref_r <= 16'h0000;
            end else if (crc_ref_r == 16'h0000) begin
                crc_ref_r <= st_r.checksum;
            end
        end
    end

    // outputs
    assign rd_data_out               = st_r.rdata;
    assign rd_ack_out                = rd_ack_r;
    assign offset_code_out           = st_r.offset;  // RQ2
    assign gain_code_out             = st_r.gain;    // RQ3
    assign locked_out                = !unlocked;
    assign config_crc_error_flag_out = st_r.crc_ok;  // RQ12
    assign scan_start_out            = st_r.next_cycle;
    assign go_standby_out            = st_r.go_standby;
    assign go_shutdown_out           = st_r.go_shutdown;

    // assertions
    a_unlocked_crc_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ6
        unlocked |=> (st_r.checksum == 16'h0000 || !unlocked))
        else $error("checksum not zero while unlocked");
    a_locked_write_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ7
        (!unlocked && wr_in.valid && wr_in.cmd[5:2] == `ARM_ADDR_GAIN) |=> $stable(st_r.gain))
        else $error("write accepted while locked");
    a_crc_hold_stopped: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ8
        (!unlocked && !master_clock_run_in && $past(!unlocked)) |=> $stable(st_r.crc_acc))
        else $error("checksum moved with clock stopped");
    a_wrong_addr_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ10
        (rd_valid_in && rd_cmd_in[7:6] != DEV_ADDR) |=> !rd_ack_out)
        else $error("answered foreign address");
    a_zero_interval_now: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ1
        (st_r.seq == arm_pkg::ARM_SCAN && scan_done_in && conversion_mode_field_in == `ARM_MODE_CONT
         && st_r.interval == 24'h000000) |=> scan_start_out)
        else $error("zero interval did not restart at once");
    a_oneshot_ends: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ11
        (st_r.seq == arm_pkg::ARM_SCAN && scan_done_in && conversion_mode_field_in != `ARM_MODE_CONT)
        |=> (go_standby_out ^ go_shutdown_out) && !scan_start_out)
        else $error("one-shot did not end");
    a_interval_wait: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ1
        (st_r.seq == arm_pkg::ARM_SCAN && scan_done_in && conversion_mode_field_in == `ARM_MODE_CONT
         && st_r.interval == 24'h000002 && master_clock_run_in) ##1 master_clock_run_in[*2]
        |=> scan_start_out)
        else $error("interval count wrong");
    a_password_write: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RQ7
        (wr_in.valid && addr_hit(wr_in.cmd) && wr_in.cmd[5:2] == `ARM_ADDR_PASSWORD)
        |=> st_r.password == $past(wr_in.data[7:0]))
        else $error("password write lost");
endmodule
